// [shared/asq_params.svh]
// Constants of the sample queue controller.
// Assumes inclusion by bare name from design and bench files.
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH
`define ASQ_ADDR_DATA      8'h00
`define ASQ_ADDR_STATUS    8'h01
`define ASQ_ADDR_LEVEL_LO  8'h02
`define ASQ_ADDR_LEVEL_HI  8'h03
`define ASQ_ADDR_MARK_LO   8'h04
`define ASQ_ADDR_MARK_HI   8'h05
`define ASQ_ADDR_CONFIG    8'h06
`define ASQ_ADDR_CMD       8'h07
`define ASQ_ADDR_ERROR     8'h08
`define ASQ_CMD_FLUSH      8'hB0
`define ASQ_OVERREAD_HDR   8'h80
`define ASQ_OVERREAD_LO    8'h00
`define ASQ_OVERREAD_HI    8'h80
`define ASQ_HDR_DATA       8'h80
`define ASQ_HDR_ACC_BIT    2
`define ASQ_HDR_AUX_BIT    4
`define ASQ_HDR_DROP       8'h50
`define ASQ_HDR_CFG        8'h48
`define ASQ_DROP_AUX_BIT   2
`define ASQ_DROP_ACC_BIT   0
`define ASQ_CFG_HDR_BIT    0
`define ASQ_CFG_TAG1_BIT   1
`define ASQ_CFG_TAG2_BIT   2
`define ASQ_CFG_IN1_BIT    3
`define ASQ_CFG_IN2_BIT    4
`define ASQ_CFG_PERF_BIT   5
`define ASQ_ST_FULL_BIT    0
`define ASQ_ST_MARK_BIT    1
`define ASQ_ST_ERR_BIT     2
`define ASQ_FEATURE_HZ     50
`define ASQ_CLK_HZ         125000000
`endif

// [shared/asq_pkg.sv]
// Types of the sample queue controller.
// Assumes no surroundings.
`default_nettype none
package asq_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} asq_bus_t;
	typedef struct packed {
		logic        tick;
		logic        acc_en;
		logic        aux_en;
		logic        acc_valid;
		logic        aux_valid;
		logic        acc_lost;
		logic        aux_lost;
		logic        cfg_change;
		logic [7:0]  cfg_payload;
		logic        aux_size_change;
		logic [15:0] acc_word;
		logic [15:0] aux_word;
	} asq_sample_t;
	typedef enum logic [1:0] {ASQ_IDLE, ASQ_HDR, ASQ_BODY} asq_rd_t;
endpackage
`default_nettype wire

// [logic/asq_queue_ctrl.sv]
// Sample queue of a motion sensor with frame assembly and level interrupts.
// Assumes same-clock sample source and register master; pins are async.
`include "asq_params.svh"
`default_nettype none
module asq_queue_ctrl
	import asq_pkg::*;
#(
	parameter int DEPTH     = 1024,
	parameter int AW        = 10,
	parameter int MAX_FRAME = 7
) (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	input  wire asq_bus_t    bus,
	output logic      [7:0]  rdata,
	input  wire asq_sample_t smp,
	input  wire logic        pin1_level,
	input  wire logic        pin2_level,
	input  wire logic        feature_fatal,
	output logic             full_int,
	output logic             mark_int,
	output logic             error_int,
	output logic             feature_tick,
	output logic             perf_mode
);
	localparam int FEAT_DIV = `ASQ_CLK_HZ / `ASQ_FEATURE_HZ;
	localparam logic [AW:0] FULL_TH = (AW+1)'(DEPTH - 2 * MAX_FRAME);

	logic [7:0]  mem [DEPTH];
	logic [AW-1:0] wp_reg, rp_reg, fstart_reg;
	logic [AW:0]   lvl_reg;
	logic [7:0]  cfg_reg, mark_lo_reg, mark_hi_reg, status_word;
	logic        err_lost_reg, sreq_reg, ovr_odd_reg;
	logic        full_reg, mark_reg, err_reg;
	logic [1:0]  p1_reg, p2_reg;
	logic        cfg_pend_reg;
	logic [7:0]  flen_reg, fcnt_reg;
	logic [7:0]  hdr_bytes [MAX_FRAME];
	logic [2:0]  nb;
	logic [25:0] fdiv_reg;
	asq_rd_t     rst_reg;

	wire hdr_mode = cfg_reg[`ASQ_CFG_HDR_BIT];
	wire is_data  = bus.rd && bus.addr == `ASQ_ADDR_DATA;
	wire is_flush = bus.wr && bus.addr == `ASQ_ADDR_CMD && bus.wdata == `ASQ_CMD_FLUSH;
	wire hdr_chg  = bus.wr && bus.addr == `ASQ_ADDR_CONFIG &&
		bus.wdata[`ASQ_CFG_HDR_BIT] != hdr_mode;
	wire en_chg   = !hdr_mode && (smp.acc_en != sreq_reg);
	wire auto_fl  = hdr_chg || en_chg || smp.aux_size_change;
	wire flush    = is_flush || auto_fl;
	wire [15:0]   mark_word = {mark_hi_reg, mark_lo_reg};
	wire [AW:0]   mark      = mark_word[AW:0];
	wire [AW-1:0] rd_ptr = rp_reg;
	wire          empty  = lvl_reg == '0;
	wire [1:0]    tag    = {p2_reg[1] & cfg_reg[`ASQ_CFG_TAG2_BIT] & cfg_reg[`ASQ_CFG_IN2_BIT],
		p1_reg[1] & cfg_reg[`ASQ_CFG_TAG1_BIT] & cfg_reg[`ASQ_CFG_IN1_BIT]};

	// Frame builder: all sensors sampled on the same grid tick
	wire acc_in  = smp.acc_en && smp.acc_valid;
	wire aux_in  = smp.aux_en && smp.aux_valid;
	wire any_in  = acc_in || aux_in;
	wire drop_ev = hdr_mode && cfg_pend_reg && !any_in &&
		(smp.acc_lost || smp.aux_lost);
	always_comb begin
		for (int i = 0; i < MAX_FRAME; i++) hdr_bytes[i] = 8'h00;
		nb = 3'd0;
		if (smp.tick) begin
			if (hdr_mode && smp.cfg_change) begin
				hdr_bytes[0] = `ASQ_HDR_CFG;
				hdr_bytes[1] = smp.cfg_payload;
				nb = 3'd2;
			end else if (drop_ev) begin
				hdr_bytes[0] = `ASQ_HDR_DROP;
				hdr_bytes[1] = {5'h00, smp.aux_lost, 1'b0, smp.acc_lost};
				nb = 3'd2;
			end else if (any_in) begin
				if (hdr_mode) begin
					hdr_bytes[0] = `ASQ_HDR_DATA | (8'(aux_in) << `ASQ_HDR_AUX_BIT) |
						(8'(acc_in) << `ASQ_HDR_ACC_BIT) | {6'h00, tag};
					nb = 3'd1;
				end
				if (aux_in) begin
					hdr_bytes[nb]        = smp.aux_word[7:0];
					hdr_bytes[3'(nb+1)]  = smp.aux_word[15:8];
					nb = 3'(nb + 2);
				end
				if (acc_in) begin
					hdr_bytes[nb]        = smp.acc_word[7:0];
					hdr_bytes[3'(nb+1)]  = smp.acc_word[15:8];
					nb = 3'(nb + 2);
				end
			end
		end
	end
	wire room  = (lvl_reg + (AW+1)'(nb)) <= (AW+1)'(DEPTH);
	wire store = clk_en && nb != 3'd0 && room && !flush;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			p1_reg <= 2'b00;
			p2_reg <= 2'b00;
		end else if (clk_en) begin
			p1_reg <= {p1_reg[0], pin1_level};
			p2_reg <= {p2_reg[0], pin2_level};
		end
	end

	// Config-change window: drops only follow a config frame
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_pend_reg <= 1'b0;
			sreq_reg     <= 1'b0;
		end else if (clk_en) begin
			sreq_reg <= smp.acc_en;
			if (smp.tick && smp.cfg_change)
				cfg_pend_reg <= 1'b1;
			else if (smp.tick && any_in)
				cfg_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (store)
			for (int i = 0; i < MAX_FRAME; i++)
				if (3'(i) < nb) mem[AW'(wp_reg + AW'(i))] <= hdr_bytes[i];
	end

	wire rd_take    = clk_en && is_data && !empty;
	wire frame_done = rd_take && fcnt_reg != 8'h00 && 8'(fcnt_reg + 8'h01) == flen_reg;
	// Write pointer: advances by the bytes of each stored frame
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			wp_reg <= '0;
		else if (clk_en) begin
			if (flush)
				wp_reg <= '0;
			else if (store)
				wp_reg <= AW'(wp_reg + AW'(nb));
		end
	end

	// Read pointers: partial frame rewinds to its start when reading stops
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rp_reg     <= '0;
			fstart_reg <= '0;
			fcnt_reg   <= 8'h00;
			flen_reg   <= 8'h00;
		end else if (clk_en) begin
			if (flush) begin
				rp_reg     <= '0;
				fstart_reg <= '0;
				fcnt_reg   <= 8'h00;
			end else if (rd_take) begin
				rp_reg <= AW'(rp_reg + 1'b1);
				if (fcnt_reg == 8'h00) begin
					flen_reg <= frame_len(mem[rd_ptr]);
					fcnt_reg <= 8'h01;
				end else if (frame_done) begin
					fstart_reg <= AW'(rp_reg + 1'b1);
					fcnt_reg   <= 8'h00;
				end else
					fcnt_reg <= fcnt_reg + 8'h01;
			end else if (!is_data && fcnt_reg != 8'h00) begin
				rp_reg   <= fstart_reg;
				fcnt_reg <= 8'h00;
			end
		end
	end

	// Fill level: a frame leaves only once its last byte was read
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			lvl_reg <= '0;
		else if (clk_en) begin
			if (flush)
				lvl_reg <= '0;
			else
				lvl_reg <= lvl_reg + (store ? (AW+1)'(nb) : '0) -
					(frame_done ? (AW+1)'(flen_reg) : '0);
		end
	end

	// Headerless overread byte phase: low byte first, then high byte
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			ovr_odd_reg <= 1'b0;
		else if (clk_en)
			ovr_odd_reg <= (is_data && empty) ? !ovr_odd_reg : 1'b0;
	end

	function automatic logic [7:0] frame_len(input logic [7:0] h);
		logic [7:0] n;
		n = 8'h00;
		if (!hdr_mode) n = 8'(2 * (int'(acc_in | sreq_reg)));
		else if (h[7:6] == 2'b01) n = 8'h02;
		else if (h[7]) n = 8'(1 + (h[`ASQ_HDR_AUX_BIT] ? 2 : 0) + (h[`ASQ_HDR_ACC_BIT] ? 2 : 0));
		else n = 8'h01;
		return (n == 8'h00) ? 8'h02 : n;
	endfunction

	// Registers; status reads clear latches only once level fell
	wire full_now = lvl_reg > FULL_TH;
	wire mark_now = mark != '0 && lvl_reg >= mark;
	wire st_rd    = clk_en && bus.rd && bus.addr == `ASQ_ADDR_STATUS;
	wire rd_idle  = rst_reg == ASQ_IDLE && !is_data;
	// Host registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_reg     <= 8'h00;
			mark_lo_reg <= 8'h00;
			mark_hi_reg <= 8'h00;
		end else if (clk_en) begin
			if (bus.wr && bus.addr == `ASQ_ADDR_CONFIG)   cfg_reg     <= bus.wdata;
			if (bus.wr && bus.addr == `ASQ_ADDR_MARK_LO)  mark_lo_reg <= bus.wdata;
			if (bus.wr && bus.addr == `ASQ_ADDR_MARK_HI)  mark_hi_reg <= bus.wdata;
		end
	end

	// Full latch: set wins over the status-read clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			full_reg <= 1'b0;
		else if (clk_en) begin
			if (full_now && rd_idle)
				full_reg <= 1'b1;
			else if (st_rd && !full_now)
				full_reg <= 1'b0;
		end
	end

	// Watermark latch: same hold-off and clear as the full latch
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			mark_reg <= 1'b0;
		else if (clk_en) begin
			if (mark_now && rd_idle)
				mark_reg <= 1'b1;
			else if (st_rd && !mark_now)
				mark_reg <= 1'b0;
		end
	end

	// Fatal error latch: only the flush command clears it, not an automatic flush, unless still reported
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			err_reg <= 1'b0;
		else if (clk_en) begin
			if (feature_fatal)
				err_reg <= 1'b1;
			else if (is_flush)
				err_reg <= 1'b0;
		end
	end

	// Status byte as the host reads it
	always_comb begin
		status_word                   = 8'h00;
		status_word[`ASQ_ST_FULL_BIT] = full_reg;
		status_word[`ASQ_ST_MARK_BIT] = mark_reg;
		status_word[`ASQ_ST_ERR_BIT]  = err_reg;
	end

	// Lost-write error flag, set wins over read clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) err_lost_reg <= 1'b0;
		else if (clk_en) begin
			if (smp.tick && nb != 3'd0 && !room) err_lost_reg <= 1'b1;
			else if (bus.rd && bus.addr == `ASQ_ADDR_ERROR) err_lost_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) rdata <= 8'h00;
		else if (clk_en && bus.rd) begin
			case (bus.addr)
				`ASQ_ADDR_DATA: begin
					if (!empty) rdata <= mem[rd_ptr];
					else if (hdr_mode) rdata <= `ASQ_OVERREAD_HDR;
					else rdata <= ovr_odd_reg ? `ASQ_OVERREAD_HI : `ASQ_OVERREAD_LO;
				end
				`ASQ_ADDR_STATUS:   rdata <= status_word;
				`ASQ_ADDR_LEVEL_LO: rdata <= lvl_reg[7:0];
				`ASQ_ADDR_LEVEL_HI: rdata <= 8'(lvl_reg >> 8);
				`ASQ_ADDR_MARK_LO:  rdata <= mark_lo_reg;
				`ASQ_ADDR_MARK_HI:  rdata <= mark_hi_reg;
				`ASQ_ADDR_CONFIG:   rdata <= cfg_reg;
				`ASQ_ADDR_ERROR:    rdata <= {7'h00, err_lost_reg};
				default:            rdata <= 8'h00;
			endcase
		end
	end

	// Feature engine input rate divider
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) fdiv_reg <= '0;
		else if (clk_en) fdiv_reg <= (fdiv_reg == 26'(FEAT_DIV - 1)) ? '0 : fdiv_reg + 26'd1;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) rst_reg <= ASQ_IDLE;
		else if (clk_en) begin
			case (rst_reg)
				ASQ_IDLE: rst_reg <= is_data ? ASQ_HDR : ASQ_IDLE;
				ASQ_HDR:  rst_reg <= is_data ? ASQ_BODY : ASQ_IDLE;
				ASQ_BODY: rst_reg <= is_data ? ASQ_BODY : ASQ_IDLE;
				default:  rst_reg <= ASQ_IDLE;
			endcase
		end
	end

	assign feature_tick = fdiv_reg == '0;
	assign perf_mode    = cfg_reg[`ASQ_CFG_PERF_BIT];
	assign full_int     = full_reg;
	assign mark_int     = mark_reg;
	assign error_int    = err_reg;
endmodule
`default_nettype wire

// [bench/asq_queue_checker.sv]
// Port checker of the sample queue controller.
// Assumes one clock domain and a bind onto each controller instance.
`include "asq_params.svh"
`default_nettype none
module asq_queue_checker
	import asq_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       nrst,
	input wire logic       clk_en,
	input wire asq_bus_t   bus,
	input wire logic [7:0] rdata,
	input wire logic       feature_fatal,
	input wire logic       full_int,
	input wire logic       mark_int,
	input wire logic       error_int,
	input wire logic       feature_tick,
	input wire logic       perf_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_q;
	logic rd_st;
	logic wr_fl;
	assign rd_q = bus.rd && bus.addr == `ASQ_ADDR_DATA;
	assign rd_st = bus.rd && clk_en && bus.addr == `ASQ_ADDR_STATUS;
	assign wr_fl = bus.wr && bus.addr == `ASQ_ADDR_CMD && bus.wdata == `ASQ_CMD_FLUSH;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	mark_quiet_a: assert property ($rose(mark_int) |-> !$past(rd_q) && !$past(rd_q, 2))
		else $error("watermark flag rose during a data read");
	full_quiet_a: assert property ($rose(full_int) |-> !$past(rd_q) && !$past(rd_q, 2))
		else $error("full flag rose during a data read");
	mark_clear_a: assert property ($fell(mark_int) |-> $past(rd_st))
		else $error("watermark flag cleared without status read");
	full_clear_a: assert property ($fell(full_int) |-> $past(rd_st))
		else $error("full flag cleared without status read");
	err_set_a: assert property (feature_fatal && clk_en |=> error_int)
		else $error("fatal error not shown in status");
	err_hold_a: assert property (error_int && clk_en && !wr_fl |=> error_int)
		else $error("error status dropped on its own");
	perf_bit_a: assert property (bus.wr && clk_en && bus.addr == `ASQ_ADDR_CONFIG
		|=> perf_mode == $past(bus.wdata[`ASQ_CFG_PERF_BIT]))
		else $error("performance bit does not follow config write");
	tick_pulse_a: assert property (feature_tick && clk_en |=> !feature_tick [*8])
		else $error("feature tick repeated too soon");
	rdata_hold_a: assert property (clk_en && !bus.rd |=> $stable(rdata))
		else $error("read data changed without a read");
endmodule
bind asq_queue_ctrl asq_queue_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
	.bus(bus), .rdata(rdata), .feature_fatal(feature_fatal), .full_int(full_int),
	.mark_int(mark_int), .error_int(error_int), .feature_tick(feature_tick),
	.perf_mode(perf_mode));
`default_nettype wire

// [bench/asq_host_model.sv]
// Host model: single register writes and back-to-back read bursts.
// Assumes the controller clock; read data stand one cycle after each read.
`default_nettype none
module asq_host_model
	import asq_pkg::*;
(
	input  wire logic       clk_sys,
	output asq_bus_t        bus,
	input  wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [8];
	initial bus = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask
	// Reads with no gap, so a frame is not rewound mid-burst
	task automatic rd(input logic [7:0] a, input int n);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			if (i == n - 1) bus.rd <= 1'b0;
			#1 got[i] = rdata;
		end
	endtask
endmodule
`default_nettype wire

// [bench/accel_sample_queue_control_tb_top.sv]
// Testbench of the sample queue controller with a host model.
// Assumes a reduced queue depth of 64 bytes.
`include "asq_params.svh"
`default_nettype none
module accel_sample_queue_control_tb_top
	import asq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, nrst, clk_en, pin1_level, pin2_level, feature_fatal;
	logic full_int, mark_int, error_int, feature_tick, perf_mode;
	logic [7:0] rdata;
	asq_bus_t bus;
	asq_sample_t smp;
	int n_fail = 0;
	int total_checks = 0;
	asq_queue_ctrl #(.DEPTH(64), .AW(6), .MAX_FRAME(7)) DUT (.clk_sys(clk_sys), .nrst(nrst),
		.clk_en(clk_en), .bus(bus), .rdata(rdata), .smp(smp), .pin1_level(pin1_level),
		.pin2_level(pin2_level), .feature_fatal(feature_fatal), .full_int(full_int),
		.mark_int(mark_int), .error_int(error_int), .feature_tick(feature_tick),
		.perf_mode(perf_mode));
	asq_host_model host (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));
	initial begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: byte %h, want %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: flag %b, want %b", $time, g, e);
		end
	endtask
	task automatic wait_hi(input int s);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_sys);
			#1 if ((s == 0 ? mark_int : full_int) === 1'b1) return;
		end
		n_fail++;
		$display("wrong value at %0t: flag never rose", $time);
		give_verdict();
	endtask
	task automatic push(input logic va, input logic lost, input logic cfg);
		@(posedge clk_sys);
		smp.tick <= 1'b1;
		smp.acc_valid <= va;
		smp.acc_lost <= lost;
		smp.cfg_change <= cfg;
		@(posedge clk_sys);
		smp.tick <= 1'b0;
	endtask
	task automatic t_frame();
		pin1_level <= 1'b1;
		pin2_level <= 1'b1;
		host.wr(`ASQ_ADDR_CONFIG, 8'h1F);
		push(1, 0, 0);
		host.rd(`ASQ_ADDR_LEVEL_LO, 1);
		chk8(host.got[0], 8'h03);
		host.rd(`ASQ_ADDR_DATA, 1);
		chk8(host.got[0], 8'h87);
		host.rd(`ASQ_ADDR_DATA, 6);
		chk8(host.got[0], 8'h87);
		chk8(host.got[2], 8'hA5);
		chk8(host.got[5], `ASQ_OVERREAD_HDR);
	endtask
	task automatic t_drop();
		host.wr(`ASQ_ADDR_CONFIG, 8'h01);
		push(0, 1, 1);
		push(0, 1, 0);
		host.rd(`ASQ_ADDR_DATA, 4);
		chk8(host.got[0], `ASQ_HDR_CFG);
		chk8(host.got[2], `ASQ_HDR_DROP);
		chk8(host.got[3], 8'h01);
	endtask
	task automatic t_mark();
		host.wr(`ASQ_ADDR_MARK_LO, 8'h02);
		push(1, 0, 0);
		wait_hi(0);
		host.rd(`ASQ_ADDR_STATUS, 1);
		chk8(host.got[0] & 8'h02, 8'h02);
		chk1(mark_int, 1'b1);
		host.wr(`ASQ_ADDR_CMD, `ASQ_CMD_FLUSH);
		host.rd(`ASQ_ADDR_LEVEL_LO, 1);
		chk8(host.got[0], 8'h00);
		host.rd(`ASQ_ADDR_STATUS, 1);
		chk1(mark_int, 1'b0);
	endtask
	task automatic t_full();
		repeat (16) push(1, 0, 0);
		@(posedge clk_sys);
		#1 chk1(full_int, 1'b0);
		push(1, 0, 0);
		wait_hi(1);
	endtask
	task automatic t_plain();
		host.wr(`ASQ_ADDR_CONFIG, 8'h00);
		host.rd(`ASQ_ADDR_LEVEL_LO, 1);
		chk8(host.got[0], 8'h00);
		host.rd(`ASQ_ADDR_DATA, 2);
		chk8(host.got[0], `ASQ_OVERREAD_LO);
		chk8(host.got[1], `ASQ_OVERREAD_HI);
	endtask
	task automatic t_err();
		@(posedge clk_sys) feature_fatal <= 1'b1;
		@(posedge clk_sys) feature_fatal <= 1'b0;
		#1 chk1(error_int, 1'b1);
		host.wr(`ASQ_ADDR_CMD, `ASQ_CMD_FLUSH);
		#1 chk1(error_int, 1'b0);
		host.wr(`ASQ_ADDR_CONFIG, 8'h20);
		#1 chk1(perf_mode, 1'b1);
		host.rd(8'h3C, 1);
		chk8(host.got[0], 8'h00);
	endtask
	initial begin
		nrst = 0;
		clk_en = 1;
		pin1_level = 0;
		pin2_level = 0;
		feature_fatal = 0;
		smp = '0;
		smp.acc_en = 1;
		smp.cfg_payload = 8'h01;
		smp.acc_word = 16'hA5C3;
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		t_frame();
		t_drop();
		t_mark();
		t_full();
		t_plain();
		t_err();
		give_verdict();
	end
endmodule
`default_nettype wire
